// ---- core/sccl_cfg.svh ----
// constants for the per-channel configuration latch bank
// included by the package and the design modules; definitions only
`ifndef SCCL_CFG_SVH
`define SCCL_CFG_SVH
`define SCCL_NUM_CH 4
`define SCCL_CH_W 2
`define SCCL_DATA_W 8
`define SCCL_CTRL_W 2
// latch field positions within one channel's write word
`define SCCL_BIT_TXCK 0
`define SCCL_BIT_TX_RATE 1
`define SCCL_BIT_REFRAME 2
`define SCCL_BIT_RXPWR 3
`define SCCL_BIT_RX_SELFTEST 4
`define SCCL_BIT_TX_SELFTEST 5
`define SCCL_BIT_SEC_DRV 6
`define SCCL_BIT_PRI_DRV 7
`define SCCL_WORD_W 8
// initialization values of the latches
`define SCCL_RST_TXCK 1'h1
`define SCCL_RST_TX_RATE 1'h0
`define SCCL_RST_REFRAME 1'h1
`define SCCL_RST_RXPWR 1'h0
`define SCCL_RST_RX_SELFTEST 1'h1
`define SCCL_RST_TX_SELFTEST 1'h1
`define SCCL_RST_SEC_DRV 1'h0
`define SCCL_RST_PRI_DRV 1'h0
// pll multipliers
`define SCCL_PLL_MULT_FULL 5'h0A
`define SCCL_PLL_MULT_DOUBLE 5'h14
`endif

// ---- core/sccl_pkg.sv ----
// types for the per-channel configuration latch bank
// assumes sccl_cfg.svh is on the include path
`include "sccl_cfg.svh"
package sccl_pkg;
    // one channel's stored configuration
    typedef struct packed {
        logic primary_out_drive_en;
        logic secondary_out_drive_en;
        logic tx_selftest_disable;
        logic rx_selftest_disable;
        logic rx_channel_power_on;
        logic reframe_enable;
        logic tx_pll_rate_sel;
        logic tx_clock_source_sel;
    } sccl_latch_type;
    // derived controls sent to one channel's datapath
    typedef struct packed {
        logic tx_reg_on_ref;
        logic phase_buf_bypass;
        logic tx_ddr_capture;
        logic [4:0] pll_mult;
        logic tx_clk_out_double;
        logic framer_run;
        logic rx_analog_on;
        logic rx_selftest_on;
        logic tx_selftest_on;
        logic primary_drv_on;
        logic secondary_drv_on;
        logic tx_logic_on;
        logic rate_cfg_invalid;
    } sccl_ctrl_type;
    // host write request
    typedef struct packed {
        logic valid;
        logic [`SCCL_CH_W-1:0] ch;
        logic [`SCCL_WORD_W-1:0] data;
    } sccl_wr_type;
endpackage

// ---- core/sccl_chan.sv ----
// one channel's latches and derived control decoding
// assumes synchronous reset and clock enable from the bank top
`timescale 1ns/1ns
`include "sccl_cfg.svh"
module sccl_chan (
    input wire logic ref_clk_i, // 10 MHz clock
    input wire logic rst_i, // sync reset, high
    input wire logic ce_i, // clock enable
    input wire logic wr_i, // write this channel
    input wire logic [`SCCL_WORD_W-1:0] data_i, // latch word
    input wire logic dev_rst_i, // synced device reset, high
    input wire logic speed_range_sel_i, // synced speed range
    output sccl_pkg::sccl_latch_type lat_o, // stored latches
    output sccl_pkg::sccl_ctrl_type ctrl_o // derived controls
);
    sccl_pkg::sccl_latch_type lat_r;
    sccl_pkg::sccl_latch_type lat_nxt;
    sccl_pkg::sccl_ctrl_type ctrl_r;
    sccl_pkg::sccl_ctrl_type ctrl_nxt;

    // write word maps straight onto the latch fields
    always_comb begin
        lat_nxt = sccl_pkg::sccl_latch_type'(data_i);
    end

    // latches hold until rewritten or reset
    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            lat_r.tx_clock_source_sel <= `SCCL_RST_TXCK;
            lat_r.tx_pll_rate_sel <= `SCCL_RST_TX_RATE;
            lat_r.reframe_enable <= `SCCL_RST_REFRAME;
            lat_r.rx_channel_power_on <= `SCCL_RST_RXPWR;
            lat_r.rx_selftest_disable <= `SCCL_RST_RX_SELFTEST;
            lat_r.tx_selftest_disable <= `SCCL_RST_TX_SELFTEST;
            lat_r.secondary_out_drive_en <= `SCCL_RST_SEC_DRV;
            lat_r.primary_out_drive_en <= `SCCL_RST_PRI_DRV;
        end else if (ce_i && wr_i) begin
            lat_r <= lat_nxt;
        end
    end

    // decode latches into datapath controls
    always_comb begin
        ctrl_nxt.tx_reg_on_ref = lat_r.tx_clock_source_sel;
        ctrl_nxt.phase_buf_bypass = lat_r.tx_clock_source_sel;
        ctrl_nxt.tx_ddr_capture = lat_r.tx_clock_source_sel
            & lat_r.tx_pll_rate_sel;
        ctrl_nxt.pll_mult = lat_r.tx_pll_rate_sel ?
            `SCCL_PLL_MULT_DOUBLE : `SCCL_PLL_MULT_FULL;
        ctrl_nxt.tx_clk_out_double = lat_r.tx_pll_rate_sel;
        ctrl_nxt.framer_run = lat_r.reframe_enable;
        ctrl_nxt.rx_analog_on = lat_r.rx_channel_power_on;
        ctrl_nxt.rx_selftest_on = ~lat_r.rx_selftest_disable;
        ctrl_nxt.tx_selftest_on = ~lat_r.tx_selftest_disable;
        // device reset overrides both drivers on every channel
        ctrl_nxt.primary_drv_on = lat_r.primary_out_drive_en
            & ~dev_rst_i;
        ctrl_nxt.secondary_drv_on = lat_r.secondary_out_drive_en
            & ~dev_rst_i;
        ctrl_nxt.tx_logic_on = lat_r.primary_out_drive_en
            | lat_r.secondary_out_drive_en;
        // flagged only; host is expected never to set this
        ctrl_nxt.rate_cfg_invalid = lat_r.tx_pll_rate_sel
            & ~speed_range_sel_i;
    end

    // registered controls so every output is a flip-flop
    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            ctrl_r <= '0;
        end else if (ce_i) begin
            ctrl_r <= ctrl_nxt;
        end
    end

    assign lat_o = lat_r;
    assign ctrl_o = ctrl_r;

    AST_WRITE_HOLD: assert property (
        @(posedge ref_clk_i) disable iff (rst_i)
        !(ce_i && wr_i) |=> lat_r == $past(lat_r))
        else $error("latch changed without write");
    AST_DRV_OFF_RST: assert property (
        @(posedge ref_clk_i) disable iff (rst_i)
        ce_i && dev_rst_i |=> !ctrl_r.primary_drv_on
        && !ctrl_r.secondary_drv_on)
        else $error("driver on during device reset");
    AST_DDR: assert property (
        @(posedge ref_clk_i) disable iff (rst_i)
        ce_i |=> ctrl_r.tx_ddr_capture == ($past(lat_r.tx_clock_source_sel)
        && $past(lat_r.tx_pll_rate_sel)))
        else $error("ddr capture mismatch");
endmodule

// ---- core/sccl_bank.sv ----
// four-channel configuration latch bank with derived controls
// assumes the host write port is synchronous to ref_clk_i; device
// reset and speed range pins are asynchronous and are synchronised
`timescale 1ns/1ns
`include "sccl_cfg.svh"
module sccl_bank (
    input wire logic ref_clk_i, // 10 MHz clock
    input wire logic rst_i, // sync reset, high
    input wire logic ce_i, // clock enable
    input wire sccl_pkg::sccl_wr_type wr_i, // host latch write
    input wire logic dev_rst_n_i, // device reset pin, low
    input wire logic [`SCCL_NUM_CH-1:0] speed_range_sel_i, // pins
    input wire logic [`SCCL_NUM_CH-1:0] tx_input_clock_i, // tx clocks
    output logic [`SCCL_NUM_CH-1:0] tx_clock_source_sel_o, // latch
    output logic [`SCCL_NUM_CH-1:0] tx_input_clock_sel_o, // tx clk use
    output sccl_pkg::sccl_ctrl_type [`SCCL_NUM_CH-1:0] ctrl_o, // ctrls
    output logic [`SCCL_NUM_CH-1:0] cfg_invalid_o // rate misuse seen
);
    logic dev_rst_n_s1_r;
    logic dev_rst_n_s2_r;
    logic [`SCCL_NUM_CH-1:0] spd_s1_r;
    logic [`SCCL_NUM_CH-1:0] spd_s2_r;
    logic [`SCCL_NUM_CH-1:0] wr_sel;
    sccl_pkg::sccl_latch_type [`SCCL_NUM_CH-1:0] lat;
    logic [`SCCL_NUM_CH-1:0] txck_r;
    logic [`SCCL_NUM_CH-1:0] txin_sel_r;
    logic [`SCCL_NUM_CH-1:0] invalid_r;
    logic [`SCCL_NUM_CH-1:0] drv_on;
    // latch word a reset leaves in every channel
    localparam logic [`SCCL_WORD_W-1:0] lat_init = {`SCCL_RST_PRI_DRV,
        `SCCL_RST_SEC_DRV, `SCCL_RST_TX_SELFTEST, `SCCL_RST_RX_SELFTEST,
        `SCCL_RST_RXPWR, `SCCL_RST_REFRAME, `SCCL_RST_TX_RATE,
        `SCCL_RST_TXCK};

    // channel select used by every channel write strobe
    function automatic logic ch_hit(input sccl_pkg::sccl_wr_type w,
                                    input int unsigned idx);
        ch_hit = w.valid && (w.ch == idx[`SCCL_CH_W-1:0]);
    endfunction

    // two-stage synchronisers for asynchronous pins
    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            dev_rst_n_s1_r <= 1'h1;
            dev_rst_n_s2_r <= 1'h1;
            spd_s1_r <= 4'hF;
            spd_s2_r <= 4'hF;
        end else if (ce_i) begin
            dev_rst_n_s1_r <= dev_rst_n_i;
            dev_rst_n_s2_r <= dev_rst_n_s1_r;
            spd_s1_r <= speed_range_sel_i;
            spd_s2_r <= spd_s1_r;
        end
    end

    // one latch copy per channel
    genvar g;
    generate
        for (g = 0; g < `SCCL_NUM_CH; g++) begin : gen_ch
            assign wr_sel[g] = ch_hit(wr_i, g);
            sccl_chan i_sccl_chan (
                .ref_clk_i(ref_clk_i),
                .rst_i(rst_i),
                .ce_i(ce_i),
                .wr_i(wr_sel[g]),
                .data_i(wr_i.data),
                .dev_rst_i(~dev_rst_n_s2_r),
                .speed_range_sel_i(spd_s2_r[g]),
                .lat_o(lat[g]),
                .ctrl_o(ctrl_o[g])
            );
        end
    endgenerate

    // input register clock steering per channel
    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            txck_r <= 4'hF;
            txin_sel_r <= 4'h0;
        end else if (ce_i) begin
            for (int i = 0; i < `SCCL_NUM_CH; i++) begin
                txck_r[i] <= lat[i].tx_clock_source_sel;
                txin_sel_r[i] <= ~lat[i].tx_clock_source_sel;
            end
        end
    end

    // sticky record of the reserved rate combination, cleared by reset
    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            invalid_r <= 4'h0;
        end else if (ce_i) begin
            for (int i = 0; i < `SCCL_NUM_CH; i++) begin
                invalid_r[i] <= invalid_r[i] | ctrl_o[i].rate_cfg_invalid;
            end
        end
    end

    assign tx_clock_source_sel_o = txck_r;
    assign tx_input_clock_sel_o = txin_sel_r;
    assign cfg_invalid_o = invalid_r;

    // driver status gathered for the device reset check; only the
    // registered controls are read, so no glitch reaches the check
    always_comb begin
        for (int i = 0; i < `SCCL_NUM_CH; i++) begin
            drv_on[i] = ctrl_o[i].primary_drv_on
                | ctrl_o[i].secondary_drv_on;
        end
    end

    // reset release: first edge with reset low after one with it high
    sequence seq_bank_reset_release;
        rst_i ##1 !rst_i;
    endsequence
    // device reset seen on two enabled edges past the synchroniser
    sequence seq_dev_rst_held;
        (ce_i && !dev_rst_n_s2_r) ##1 (ce_i && !dev_rst_n_s2_r);
    endsequence

    AST_TXIN_EXCL: assert property (
        @(posedge ref_clk_i) disable iff (rst_i)
        (txck_r & txin_sel_r) == 4'h0)
        else $error("both input clock sources selected");
    AST_DRV_RST: assert property (
        @(posedge ref_clk_i) disable iff (rst_i)
        ce_i && !dev_rst_n_s2_r |=> ctrl_o[0].primary_drv_on == 1'b0)
        else $error("driver enabled under device reset");
    AST_DRV_ALL_OFF: assert property (
        @(posedge ref_clk_i) disable iff (rst_i)
        seq_dev_rst_held |-> drv_on == 4'h0)
        else $error("driver left on under device reset");
    AST_RST_TXCK: assert property (
        @(posedge ref_clk_i)
        seq_bank_reset_release |-> txck_r == 4'hF && txin_sel_r == 4'h0)
        else $error("clock steering wrong after reset");

    // per-channel checks of the latches, the steering and the decoded controls
    generate
        for (g = 0; g < `SCCL_NUM_CH; g++) begin : gen_chk
            AST_LAT_INIT: assert property (
                @(posedge ref_clk_i) seq_bank_reset_release
                |-> lat[g] == lat_init)
                else $error("latch init value wrong");
            AST_TXCK_FOLLOW: assert property (
                @(posedge ref_clk_i) disable iff (rst_i)
                ce_i |=> txck_r[g] == $past(lat[g].tx_clock_source_sel))
                else $error("clock source output off its latch");
            AST_TXIN_SEL: assert property (
                @(posedge ref_clk_i) disable iff (rst_i)
                ce_i |=> txin_sel_r[g] != $past(lat[g].tx_clock_source_sel))
                else $error("tx input clock not selected by latch");
            AST_PLL_MULT: assert property (
                @(posedge ref_clk_i) disable iff (rst_i)
                ce_i |=> ctrl_o[g].pll_mult == ($past(lat[g].tx_pll_rate_sel)
                    ? `SCCL_PLL_MULT_DOUBLE : `SCCL_PLL_MULT_FULL))
                else $error("pll multiplier off its latch");
            AST_RX_POWER: assert property (
                @(posedge ref_clk_i) disable iff (rst_i)
                ce_i |=> ctrl_o[g].rx_analog_on
                    == $past(lat[g].rx_channel_power_on))
                else $error("rx power control off its latch");
            AST_SELFTEST: assert property (
                @(posedge ref_clk_i) disable iff (rst_i)
                ce_i |=> ctrl_o[g].rx_selftest_on
                    != $past(lat[g].rx_selftest_disable)
                    && ctrl_o[g].tx_selftest_on
                    != $past(lat[g].tx_selftest_disable))
                else $error("selftest enable not inverse of latch");
            AST_TX_LOGIC: assert property (
                @(posedge ref_clk_i) disable iff (rst_i)
                ce_i |=> ctrl_o[g].tx_logic_on
                    == ($past(lat[g].primary_out_drive_en)
                    || $past(lat[g].secondary_out_drive_en)))
                else $error("tx logic power off its drivers");
            // clock enable low must freeze latches and controls alike
            AST_FREEZE: assert property (
                @(posedge ref_clk_i) disable iff (rst_i)
                !ce_i |=> lat[g] == $past(lat[g])
                    && ctrl_o[g] == $past(ctrl_o[g]))
                else $error("state moved with clock enable low");
        end
    endgenerate
endmodule

// ---- tb/sccl_host_model.sv ----
// host side model that loads one channel's latch word at a time
// assumes bank write port on the same rising edge as the bench clock
`timescale 1ns/1ns
`include "sccl_cfg.svh"
module sccl_host_model (
    input wire logic clk_i, // reference clock
    input wire logic [`SCCL_NUM_CH-1:0] speed_i, // speed range pins
    output sccl_pkg::sccl_wr_type wr_o // write request to the bank
);
    // idle request starts with valid low and channel and data all zero
    initial wr_o = '{1'b0, 2'h0, 8'h00};
    // held one edge; back to back calls keep valid up
    task automatic write(input logic [1:0] ch, input logic [7:0] d);
        if (d[1] && !speed_i[ch]) begin
            return;
        end
        wr_o <= '{1'b1, ch, d};
        @(posedge clk_i);
    endtask
    // drop valid and scramble the lines left behind
    task automatic release_bus();
        wr_o <= '{1'b0, ~wr_o.ch, ~wr_o.data};
        @(posedge clk_i);
    endtask
endmodule

// ---- tb/test_serdes_channel_config_latches.sv ----
// self-checking bench for the four-channel configuration latch bank
// assumes the host model drives writes and the bench owns the pins
`timescale 1ns/1ns
`include "sccl_cfg.svh"
module test_serdes_channel_config_latches;
    logic ref_clk_i = 1'h0;
    logic rst_i = 1'h1;
    logic ce_i = 1'h1;
    logic dev_rst_n_i = 1'h1;
    logic [3:0] speed = 4'hF;
    logic [3:0] txsel, inclk_sel, invalid;
    sccl_pkg::sccl_wr_type wr;
    sccl_pkg::sccl_ctrl_type [3:0] ctrl;
    logic [7:0] shadow [4];
    int miscompares = 0;
    int total_checks = 0;
    // 10 MHz reference clock
    always #50 ref_clk_i = ~ref_clk_i;
    sccl_host_model i_sccl_host_model (.clk_i(ref_clk_i),
        .speed_i(speed), .wr_o(wr));
    sccl_bank i_sccl_bank (.ref_clk_i(ref_clk_i), .rst_i(rst_i),
        .ce_i(ce_i), .wr_i(wr), .dev_rst_n_i(dev_rst_n_i),
        .speed_range_sel_i(speed), .tx_input_clock_i(4'h0),
        .tx_clock_source_sel_o(txsel), .tx_input_clock_sel_o(inclk_sel),
        .ctrl_o(ctrl), .cfg_invalid_o(invalid));
    task automatic close_out();
        if (miscompares == 0 && total_checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    task automatic cmp_ctrl(input sccl_pkg::sccl_ctrl_type g,
                            input sccl_pkg::sccl_ctrl_type e);
        total_checks++;
        if (g !== e) begin
            miscompares++;
            $display("BAD t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask
    task automatic cmp4(input logic [3:0] g, input logic [3:0] e);
        total_checks++;
        if (g !== e) begin
            miscompares++;
            $display("BAD t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask
    // decode expected from the stored word; drivers also need dev reset off
    function automatic sccl_pkg::sccl_ctrl_type exp_ctrl(
            input logic [7:0] w, input logic on);
        sccl_pkg::sccl_ctrl_type e;
        e.tx_reg_on_ref = w[0];
        e.phase_buf_bypass = w[0];
        e.tx_ddr_capture = w[0] & w[1];
        e.pll_mult = w[1] ? `SCCL_PLL_MULT_DOUBLE : `SCCL_PLL_MULT_FULL;
        e.tx_clk_out_double = w[1];
        e.framer_run = w[2];
        e.rx_analog_on = w[3];
        e.rx_selftest_on = ~w[4];
        e.tx_selftest_on = ~w[5];
        e.primary_drv_on = w[7] & on;
        e.secondary_drv_on = w[6] & on;
        e.tx_logic_on = w[6] | w[7];
        e.rate_cfg_invalid = 1'h0;
        return e;
    endfunction
    task automatic cycles(input int n);
        repeat (n) @(posedge ref_clk_i);
    endtask
    task automatic check_all(input logic on);
        logic [3:0] sel;
        for (int c = 0; c < 4; c++) begin
            sel[c] = shadow[c][0];
        end
        #1;
        for (int c = 0; c < 4; c++) begin
            cmp_ctrl(ctrl[c], exp_ctrl(shadow[c], on));
        end
        cmp4(txsel, sel);
        cmp4(inclk_sel, ~sel);
        cmp4(invalid, 4'h0);
        @(posedge ref_clk_i);
    endtask
    task automatic load(input logic [31:0] words);
        for (int c = 0; c < 4; c++) begin
            shadow[c] = words[8*c +: 8];
            i_sccl_host_model.write(2'(c), shadow[c]);
        end
        i_sccl_host_model.release_bus();
        cycles(2);
    endtask
    // watchdog cuts a hang short
    initial begin
        #2000000;
        miscompares++;
        close_out();
    end
    initial begin
        for (int c = 0; c < 4; c++) begin
            shadow[c] = 8'h35;
        end
        cycles(16);
        rst_i <= 1'h0;
        cycles(3);
        check_all(1'h1);
        load(32'h80_40_CB_0A);
        check_all(1'h1);
        speed <= 4'hD;
        load(32'h76_FF_00_83);
        check_all(1'h1);
        // writes while the clock enable is low must be ignored
        ce_i <= 1'h0;
        i_sccl_host_model.write(2'h2, 8'h00);
        i_sccl_host_model.release_bus();
        ce_i <= 1'h1;
        cycles(2);
        check_all(1'h1);
        // device reset pin kills drivers but keeps the latches
        dev_rst_n_i <= 1'h0;
        cycles(5);
        check_all(1'h0);
        dev_rst_n_i <= 1'h1;
        cycles(5);
        check_all(1'h1);
        // second reset in mid run restores init values
        rst_i <= 1'h1;
        cycles(2);
        rst_i <= 1'h0;
        for (int c = 0; c < 4; c++) begin
            shadow[c] = 8'h35;
        end
        cycles(3);
        check_all(1'h1);
        close_out();
    end
endmodule
